// ===== rtl/input_interval_stamp_fifo.sv
// trigger interval capture: ms time base, stamp buffer, result and event count
// Notes on behaviour
// - each trigger after the first since setup pushes the time elapsed since the previous trigger, unless the buffer is full.
// - intervals count the ms ticks of the prescaler, which restarts on setup and at each ms tick but not on a trigger, between consecutive triggers.
// - buffer holds eight entries, strictly first-in first-out.
// - the setup command empties the buffer.
// - each pop outside a setup cycle moves the oldest entry into the result register.
// - pop on an empty buffer writes zero to the result.
// - an event counter tied to the input counts each trigger outside a setup cycle.
`timescale 1ns/10ps
module input_interval_stamp_fifo
    import stamp_pkg::*;
(
    input  wire logic               clk,              // 100 MHz clock
    input  wire logic               srst,             // sync reset, active high
    input  wire logic               sense_in,         // monitored input pin
    input  wire setup_cmd_t         arm_capture_setup, // setup pulse with condition
    input  wire logic               pop_oldest_stamp, // retrieval pulse
    output logic      [STAMP_W-1:0] elapsed_value,    // result register
    output logic      [CNT_W-1:0]   event_count,      // trigger count register
    output logic                    stamp_empty,      // buffer empty, registered
    output logic                    stamp_full,       // buffer full, registered
    output logic                    armed             // capture set up
);
    // synchroniser stages and edge history
    logic               sync_a;           // first stage, read by sync_b only
    logic               sync_b;           // second stage, settled pin level
    logic               sense_d;          // sync_b one cycle older

    // setup state
    cond_t              cond;             // latched trigger condition
    logic               seen_first;       // an interval is open

    // time base
    logic [31:0]        div_cnt;          // cycles within the current ms
    logic [STAMP_W-1:0] ms_cnt;           // ms ticks since the last trigger

    // buffer side
    logic [STAMP_W-1:0] fifo_head;        // oldest stored interval
    logic               fifo_empty;       // buffer holds nothing
    logic               fifo_full;        // buffer holds eight entries

    // decode results
    logic               setup_go;         // setup command this cycle
    logic               rise_evt;         // settled pin went high
    logic               fall_evt;         // settled pin went low
    logic               want_rise;        // condition enters on a rising pin
    logic               trig_raw;         // condition met, armed or not
    logic               trigger;          // counted trigger
    logic               ms_tick;          // last cycle of a millisecond
    logic               ms_sat;           // interval count at its ceiling
    logic               div_restart;      // prescaler back to zero
    logic               ms_restart;       // interval count back to zero
    logic               ms_step;          // interval count moves on
    logic               push_req;         // interval to store
    logic               pop_req;          // retrieval that setup leaves alone
    logic               pop_hit;          // retrieval with an entry to hand over

    // next values for the setup, counter and result registers
    logic               next_armed;
    cond_t              next_cond;
    logic               next_seen_first;
    logic [31:0]        next_div_cnt;
    logic [STAMP_W-1:0] next_ms_cnt;
    logic [CNT_W-1:0]   next_event_count;
    logic [STAMP_W-1:0] next_elapsed;

    // first two stages; only sync_b reads the first one
    always_ff @(posedge clk) begin
        if (srst) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
        end else begin
            sync_a <= sense_in;
            sync_b <= sync_a;
        end
    end

    // low after reset; a pin idling high makes a false edge, harmless while unarmed
    always_ff @(posedge clk) begin
        if (srst) begin
            sense_d <= 1'b0;
        end else begin
            sense_d <= sync_b;
        end
    end

    // command decode
    assign setup_go = arm_capture_setup.valid;

    // edge decode; a level condition fires on entering its level
    assign rise_evt  = sync_b && !sense_d;
    assign fall_evt  = !sync_b && sense_d;
    assign want_rise = (cond == cond_rise) || (cond == cond_high);
    assign trig_raw  = want_rise ? rise_evt : fall_evt;
    assign trigger   = armed && trig_raw;

    // time base decode; the prescaler restarts on setup so the first ms is whole
    assign ms_tick     = (div_cnt == 32'(MS_CYCLES - 1));
    assign ms_sat      = (ms_cnt == '1);
    assign div_restart = setup_go || ms_tick;

    // interval count control; saturate rather than wrap to a short value
    assign ms_restart = setup_go || trigger;
    assign ms_step    = ms_tick && !ms_sat;

    // buffer requests; the first trigger after setup only opens the interval
    assign push_req = trigger && seen_first;
    assign pop_req  = pop_oldest_stamp && !setup_go;  // setup empties the buffer that cycle

    // a retrieval that finds an entry to hand over
    assign pop_hit = pop_req && !fifo_empty;

    // setup latches the condition and restarts interval tracking
    assign next_armed      = setup_go ? 1'b1 : armed;
    assign next_cond       = setup_go ? arm_capture_setup.cond : cond;
    assign next_seen_first = setup_go ? 1'b0 : (seen_first || trigger);

    // counter next values
    assign next_div_cnt     = div_restart ? 32'h0000_0000 : div_cnt + 32'h0000_0001;
    assign next_ms_cnt      = ms_restart ? STAMP_RST :
                              ms_step    ? ms_cnt + 1'b1 : ms_cnt;
    assign next_event_count = setup_go ? EVENT_RST :
                              trigger  ? event_count + 1'b1 : event_count;

    // result register: oldest entry, or zero when nothing is stored
    assign next_elapsed = pop_hit ? fifo_head :
                          pop_req ? STAMP_RST :
                                    elapsed_value;

    // armed from the first setup on
    always_ff @(posedge clk) begin
        if (srst) begin
            armed <= 1'b0;
        end else begin
            armed <= next_armed;
        end
    end

    // chosen trigger condition
    always_ff @(posedge clk) begin
        if (srst) begin
            cond <= cond_rise;
        end else begin
            cond <= next_cond;
        end
    end

    // interval open flag; setup closes it
    always_ff @(posedge clk) begin
        if (srst) begin
            seen_first <= 1'b0;
        end else begin
            seen_first <= next_seen_first;
        end
    end

    // millisecond prescaler
    always_ff @(posedge clk) begin
        if (srst) begin
            div_cnt <= 32'h0000_0000;
        end else begin
            div_cnt <= next_div_cnt;
        end
    end

    // elapsed ms since the last trigger
    always_ff @(posedge clk) begin
        if (srst) begin
            ms_cnt <= STAMP_RST;
        end else begin
            ms_cnt <= next_ms_cnt;
        end
    end

    // trigger counter
    always_ff @(posedge clk) begin
        if (srst) begin
            event_count <= EVENT_RST;
        end else begin
            event_count <= next_event_count;
        end
    end

    // result register holds until the next retrieval
    always_ff @(posedge clk) begin
        if (srst) begin
            elapsed_value <= STAMP_RST;
        end else begin
            elapsed_value <= next_elapsed;
        end
    end

    // empty copy, one cycle behind the buffer, so the output is a flop
    always_ff @(posedge clk) begin
        if (srst) begin
            stamp_empty <= 1'b1;
        end else begin
            stamp_empty <= fifo_empty;
        end
    end

    // full copy, one cycle behind the buffer
    always_ff @(posedge clk) begin
        if (srst) begin
            stamp_full <= 1'b0;
        end else begin
            stamp_full <= fifo_full;
        end
    end

    // eight-entry store; setup doubles as its flush
    stamp_fifo stamp_fifo_inst (
        .clk       (clk),
        .srst      (srst),
        .flush     (setup_go),
        .push      (push_req),
        .push_data (ms_cnt),
        .pop       (pop_req),
        .head      (fifo_head),
        .empty     (fifo_empty),
        .full      (fifo_full)
    );
endmodule

// ===== rtl/stamp_fifo.sv
// eight-entry first-in first-out store for millisecond intervals
`timescale 1ns/10ps
module stamp_fifo
    import stamp_pkg::*;
(
    input  wire logic               clk,     // system clock
    input  wire logic               srst,    // sync reset, active high
    input  wire logic               flush,   // drop all entries
    input  wire logic               push,    // write request
    input  wire logic [STAMP_W-1:0] push_data, // interval to store
    input  wire logic               pop,     // read request
    output logic      [STAMP_W-1:0] head,    // oldest entry
    output logic                    empty,   // no entries held
    output logic                    full     // all entries held
);
    logic [STAMP_W-1:0] mem [DEPTH];
    logic [PTR_W:0]     wr_ptr;
    logic [PTR_W:0]     rd_ptr;
    wire                do_push = push && !full;
    wire                do_pop  = pop && !empty;

    // pointer flags: extra msb tells full from empty
    assign empty = (wr_ptr == rd_ptr);
    assign full  = (wr_ptr[PTR_W] != rd_ptr[PTR_W]) &&
                   (wr_ptr[PTR_W-1:0] == rd_ptr[PTR_W-1:0]);
    assign head  = mem[rd_ptr[PTR_W-1:0]];

    // pointers; flush wins over traffic
    always_ff @(posedge clk) begin
        if (srst || flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

    // storage, no reset needed
    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wr_ptr[PTR_W-1:0]] <= push_data;
        end
    end
endmodule

// ===== rtl/stamp_pkg.sv
// shared constants and carrier types for the interval stamp capture block
package stamp_pkg;
    localparam int          CLK_HZ        = 100_000_000;
    localparam int          TICK_MS       = 1;
    localparam int          MS_CYCLES     = CLK_HZ / 1000 * TICK_MS;
    localparam int          STAMP_W       = 32;
    localparam int          DEPTH         = 8;
    localparam int          PTR_W         = 3;
    localparam int          CNT_W         = 32;
    localparam logic [31:0] STAMP_RST     = 32'h0000_0000;
    localparam logic [31:0] EVENT_RST     = 32'h0000_0000;
    localparam logic [3:0]  LEVEL_RST     = 4'h0;

    // trigger condition selects
    typedef enum logic [1:0] {
        cond_rise,
        cond_fall,
        cond_high,
        cond_low
    } cond_t;

    // setup command with its condition
    typedef struct packed {
        logic  valid;
        cond_t cond;
    } setup_cmd_t;
endpackage

// ===== verif/stamp_engine_model.sv
// program engine model: turns a request into one pop pulse
`timescale 1ns/10ps
module stamp_engine_model (
    input  wire logic clk,             // clock
    input  wire logic want,            // bench asks for a pop
    output logic      pop_oldest_stamp // one-cycle pop
);
    // registered so the pop leaves just after an edge
    always_ff @(posedge clk) begin
        pop_oldest_stamp <= want;
    end
endmodule

// ===== verif/stamp_properties.sv
// port checker for the interval stamp capture block
`timescale 1ns/10ps
module stamp_checker
    import stamp_pkg::*;
(
    input wire logic               clk,               // clock
    input wire logic               srst,              // reset
    input wire logic               sense_in,          // pin
    input wire setup_cmd_t         arm_capture_setup, // setup
    input wire logic               pop_oldest_stamp,  // pop
    input wire logic [STAMP_W-1:0] elapsed_value,     // result
    input wire logic [CNT_W-1:0]   event_count,       // count
    input wire logic               stamp_empty,       // empty
    input wire logic               stamp_full,        // full
    input wire logic               armed              // armed
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // a pop that the setup pulse does not swallow
    wire go = pop_oldest_stamp && !arm_capture_setup.valid;
    wire su = arm_capture_setup.valid;
    a_empty_pop_zero: assert property (go && stamp_empty && $past(stamp_empty)
        && event_count == $past(event_count, 2) |=> elapsed_value == 0) else $error("empty pop");
    a_setup_flushes: assert property (su |-> ##2 stamp_empty) else $error("no flush");
    a_setup_zeroes: assert property (su |=> event_count == 0) else $error("count kept");
    a_count_step: assert property ($changed(event_count) && !$past(su)
        |-> event_count == $past(event_count) + 1) else $error("count step");
    a_result_cause: assert property ($changed(elapsed_value)
        |-> $past(pop_oldest_stamp) || $past(su)) else $error("result moved");
    a_setup_arms: assert property (su |=> armed) else $error("not armed");
    a_full_empty: assert property (stamp_full |-> !stamp_empty) else $error("full and empty");
    a_full_holds: assert property (stamp_full && !pop_oldest_stamp && !$past(pop_oldest_stamp)
        && !su && !$past(su) |=> stamp_full) else $error("full lost");
    c_full: cover property (stamp_full);
    c_pop: cover property (go && !stamp_empty);
    c_pop_empty: cover property (go && stamp_empty);
endmodule
bind input_interval_stamp_fifo stamp_checker stamp_checker_inst (
    .clk               (clk),
    .srst              (srst),
    .sense_in          (sense_in),
    .arm_capture_setup (arm_capture_setup),
    .pop_oldest_stamp  (pop_oldest_stamp),
    .elapsed_value     (elapsed_value),
    .event_count       (event_count),
    .stamp_empty       (stamp_empty),
    .stamp_full        (stamp_full),
    .armed             (armed)
);

// ===== verif/tb_input_interval_stamp_fifo.sv
// self-checking bench for the interval stamp capture block
`timescale 1ns/10ps
module tb_input_interval_stamp_fifo;
    import stamp_pkg::*;
    logic clk = 0, srst = 1, sense_in = 0, want = 0, pop;
    setup_cmd_t arm = '0;
    logic [31:0] res, cnt;
    logic emp, ful, arm_q;
    int bad_count = 0, total_checks = 0;
    input_interval_stamp_fifo input_interval_stamp_fifo_inst (.clk(clk), .srst(srst),
        .sense_in(sense_in), .arm_capture_setup(arm), .pop_oldest_stamp(pop),
        .elapsed_value(res), .event_count(cnt), .stamp_empty(emp), .stamp_full(ful),
        .armed(arm_q));
    stamp_engine_model stamp_engine_model_inst (.clk(clk), .want(want), .pop_oldest_stamp(pop));
    initial begin
        forever #5 clk = ~clk;
    end
    task chk(string n, logic [31:0] s, logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            bad_count++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask
    task end_sim();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task setup(cond_t c);
        arm <= '{valid: 1'b1, cond: c};
        @(posedge clk) arm.valid <= 1'b0;
        repeat (3) @(posedge clk);
        chk("armed", arm_q, 1);
    endtask
    // one high pulse gives one trigger for any condition
    task pulse();
        sense_in <= 1'b1;
        repeat (6) @(posedge clk);
        sense_in <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
    task pop_chk(logic [31:0] e);
        want <= 1'b1;
        @(posedge clk) want <= 1'b0;
        repeat (3) @(posedge clk);
        chk("elapsed", res, e);
    endtask
    // before any setup a pulse counts nothing and stores nothing
    task t_unarmed();
        chk("armed", arm_q, 0);
        pulse();
        chk("count", cnt, 0);
        chk("empty", emp, 1);
        chk("result", res, 0);
    endtask
    // every condition counts one trigger per pulse; rise and high on the way up
    task t_conds();
        for (int c = 0; c < 4; c++) begin
            setup(cond_t'(c));
            chk("count0", cnt, 0);
            sense_in <= 1'b1;
            repeat (6) @(posedge clk);
            chk("count_up", cnt, (c == 0 || c == 2) ? 32'h1 : 32'h0);
            sense_in <= 1'b0;
            repeat (6) @(posedge clk);
            pulse();
            chk("count", cnt, 2);
        end
    endtask
    // seven short gaps, then a gap across one ms tick fills the buffer;
    // the tenth trigger's stamp is dropped, so the 1 ms stamp pops last
    task t_fill_drain();
        setup(cond_rise);
        repeat (8) pulse();
        repeat (99950) @(posedge clk);
        repeat (2) pulse();
        chk("count", cnt, 10);
        chk("full", ful, 1);
        for (int i = 0; i < 7; i++) pop_chk(0);
        pop_chk(1);
        chk("empty", emp, 1);
        pop_chk(0);
    endtask
    task t_flush();
        setup(cond_fall);
        repeat (3) pulse();
        chk("empty", emp, 0);
        setup(cond_high);
        chk("empty", emp, 1);
        chk("count", cnt, 0);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        t_unarmed();
        t_conds();
        t_fill_drain();
        t_flush();
        end_sim();
    end
    initial begin
        // tests take about 100,300 cycles; the limit leaves some ten percent
        #1100000;
        bad_count++;
        end_sim();
    end
endmodule
